// ==== hdl/hcp_pkg.sv ====
// Constants for the host controller configuration header slice
package hcp_pkg;
  localparam logic [7:0]  OFS_CLASS          = 8'h08;
  localparam logic [7:0]  OFS_TENURE         = 8'h0C;
  localparam logic [7:0]  OFS_HEADER         = 8'h0E;
  localparam logic [7:0]  OFS_BASE           = 8'h10;
  localparam logic [7:0]  FUNCTION_CATEGORY  = 8'h0C;
  localparam logic [7:0]  SUBCLASS_CODE      = 8'h00;
  localparam logic [7:0]  PROG_MODEL_CODE    = 8'h10;
  localparam logic [7:0]  SELF_TEST_VALUE    = 8'h00;
  localparam logic [7:0]  HEADER_LAYOUT      = 8'h00;
  localparam logic [7:0]  TENURE_RESET       = 8'h00;
  localparam logic [7:0]  LINE_RESET         = 8'h00;
  localparam int          WIN_LSB            = 11;
  localparam int          BASE_W             = 32 - WIN_LSB;
  localparam logic [20:0] BASE_RESET         = 21'h000000;
  localparam logic [10:0] BASE_LOW_BITS      = 11'h000;
  localparam int          TENURE_MSB         = 15;
  localparam int          TENURE_LSB         = 8;
  localparam int          LINE_MSB           = 7;
  localparam int          LINE_LSB           = 0;
  localparam logic [3:0]  CMD_MEM_READ_MULT  = 4'hC;
  localparam logic [3:0]  CMD_MEM_READ_LINE  = 4'hE;
  localparam logic [3:0]  CMD_MEM_WRITE_INV  = 4'hF;
endpackage

// ==== hdl/hcp_tenure_counter.sv ====
// Bus tenure counter for initiator transactions
`timescale 1ns/10ps
module hcp_tenure_counter
  import hcp_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [CNT_W-1:0] limit_i,
  input  wire logic             frame_start_i,
  input  wire logic             xfer_active_i,
  input  wire logic             gnt_n_i,
  output logic                  expired_o,
  output logic                  tenure_stop_o
);
  if (CNT_W < 8) begin : g_bad_width
    $error("tenure counter narrower than the limit field");
  end

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             running;
  logic             next_running;

  always_comb begin
    next_count   = count;
    next_running = running;
    if (frame_start_i) begin
      next_count   = '0;
      next_running = 1'b1;
    end else if (!xfer_active_i) begin
      next_running = 1'b0;
    end else if (running && (count < limit_i)) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count   <= '0;
      running <= 1'b0;
    end else begin
      count   <= next_count;
      running <= next_running;
    end
  end

  assign expired_o     = running && (count >= limit_i);
  assign tenure_stop_o = expired_o && xfer_active_i && gnt_n_i;

  property p_count_start;
    @(posedge clk_i) disable iff (rst_i)
      frame_start_i |=> (count == '0) && running;
  endproperty
  a_count_start: assert property (p_count_start)
    else $error("tenure count did not start at zero");

  property p_count_step;
    @(posedge clk_i) disable iff (rst_i)
      (running && xfer_active_i && !frame_start_i && count < limit_i)
      |=> count == $past(count) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("tenure count did not advance");

  property p_stop_needs_gnt_off;
    @(posedge clk_i) disable iff (rst_i)
      tenure_stop_o |-> gnt_n_i && (count >= limit_i) && running;
  endproperty
  a_stop_needs_gnt_off: assert property (p_stop_needs_gnt_off)
    else $error("stop raised while granted or before limit");
endmodule

// ==== hdl/hcp_window_decode.sv ====
// Register window claim decoder for memory cycles
`timescale 1ns/10ps
module hcp_window_decode
  import hcp_pkg::*;
(
  input  wire logic [31:0]       mem_addr_i,
  input  wire logic              mem_req_i,
  input  wire logic              mem_enable_i,
  input  wire logic [BASE_W-1:0] base_i,
  output logic                   mem_hit_o
);
  assign mem_hit_o = mem_req_i && mem_enable_i &&
                     (mem_addr_i[31:WIN_LSB] == base_i);

  a_claim_gated: assert final (!(mem_hit_o && !mem_enable_i))
    else $error("window claimed with memory response disabled");
endmodule

// ==== hdl/hcp_config_header.sv ====
// Configuration header slice: class, tenure/line, header, window base
`timescale 1ns/10ps
module hcp_config_header
  import hcp_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'hA5  // Arbitrary value
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cfg_req_i,
  input  wire logic        cfg_we_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [3:0]  cfg_be_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_ack_o,
  input  wire logic        memory_response_enable_i,
  input  wire logic        mem_req_i,
  input  wire logic [31:0] mem_addr_i,
  output logic             mem_hit_o,
  input  wire logic        frame_start_i,
  input  wire logic        xfer_active_i,
  input  wire logic        gnt_n_i,
  input  wire logic [3:0]  init_cmd_i,
  output logic             tenure_expired_o,
  output logic             tenure_stop_o,
  output logic [7:0]       line_length_setting_o,
  output logic [7:0]       line_length_use_o,
  output logic [31:0]      window_base_pointer_o
);
  localparam logic [31:0] CLASS_WORD = {FUNCTION_CATEGORY, SUBCLASS_CODE,
                                        PROG_MODEL_CODE, SILICON_REVISION};

  logic [7:0]        tenure_limit;
  logic [7:0]        next_tenure_limit;
  logic [7:0]        line_length;
  logic [7:0]        next_line_length;
  logic [BASE_W-1:0] window_base;
  logic [BASE_W-1:0] next_window_base;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic              ack;
  logic              next_ack;
  logic [31:0]       base_word;
  logic [31:0]       base_merge;
  logic [31:0]       tenure_word;
  logic              wr_hit;
  logic              rd_hit;

  // Offset 0Eh lives in the upper half of the 0Ch dword
  assign tenure_word = {SELF_TEST_VALUE, HEADER_LAYOUT,
                        tenure_limit, line_length};
  // Low bits are hardwired zero: size, prefetch, type, space
  assign base_word   = {window_base, BASE_LOW_BITS};
  assign wr_hit      = cfg_req_i && cfg_we_i;
  assign rd_hit      = cfg_req_i && !cfg_we_i;

  // Byte-lane merge of a write into the base word
  always_comb begin
    base_merge = base_word;
    for (int b = 0; b < 4; b++) begin
      if (cfg_be_i[b]) begin
        base_merge[b*8 +: 8] = cfg_wdata_i[b*8 +: 8];
      end
    end
  end

  always_comb begin
    next_tenure_limit = tenure_limit;
    next_line_length  = line_length;
    next_window_base  = window_base;
    next_ack          = cfg_req_i;
    next_rdata        = 32'h00000000;
    if (wr_hit) begin
      unique case (cfg_addr_i)
        OFS_TENURE: begin
          if (cfg_be_i[1]) begin
            next_tenure_limit = cfg_wdata_i[TENURE_MSB:TENURE_LSB];
          end
          if (cfg_be_i[0]) begin
            next_line_length = cfg_wdata_i[LINE_MSB:LINE_LSB];
          end
        end
        OFS_BASE: begin
          next_window_base = base_merge[31:WIN_LSB];
        end
        default: begin
          next_window_base = window_base;
        end
      endcase
    end
    if (rd_hit) begin
      unique case (cfg_addr_i)
        OFS_CLASS:  next_rdata = CLASS_WORD;
        OFS_TENURE: next_rdata = tenure_word;
        OFS_BASE:   next_rdata = base_word;
        default:    next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tenure_limit <= TENURE_RESET;
      line_length  <= LINE_RESET;
      window_base  <= BASE_RESET;
      rdata        <= 32'h00000000;
      ack          <= 1'b0;
    end else begin
      tenure_limit <= next_tenure_limit;
      line_length  <= next_line_length;
      window_base  <= next_window_base;
      rdata        <= next_rdata;
      ack          <= next_ack;
    end
  end

  assign cfg_rdata_o           = rdata;
  assign cfg_ack_o             = ack;
  assign line_length_setting_o = line_length;
  assign window_base_pointer_o = base_word;

  // Line length only steers the three line-oriented commands
  always_comb begin
    line_length_use_o = 8'h00;
    if ((init_cmd_i == CMD_MEM_WRITE_INV) ||
        (init_cmd_i == CMD_MEM_READ_LINE) ||
        (init_cmd_i == CMD_MEM_READ_MULT)) begin
      line_length_use_o = line_length;
    end
  end

  hcp_tenure_counter #(
    .CNT_W         (8)
  ) u_tenure (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .limit_i       (tenure_limit),
    .frame_start_i (frame_start_i),
    .xfer_active_i (xfer_active_i),
    .gnt_n_i       (gnt_n_i),
    .expired_o     (tenure_expired_o),
    .tenure_stop_o (tenure_stop_o)
  );

  hcp_window_decode u_decode (
    .mem_addr_i   (mem_addr_i),
    .mem_req_i    (mem_req_i),
    .mem_enable_i (memory_response_enable_i),
    .base_i       (window_base),
    .mem_hit_o    (mem_hit_o)
  );

  sequence s_read(logic [7:0] ofs);
    cfg_req_i && !cfg_we_i && cfg_addr_i == ofs;
  endsequence

  sequence s_base_fill;
    cfg_req_i && cfg_we_i && cfg_addr_i == OFS_BASE &&
    cfg_be_i == 4'hF && cfg_wdata_i == 32'hFFFFFFFF;
  endsequence

  property p_class_word;
    @(posedge clk_i) disable iff (rst_i)
      s_read(OFS_CLASS) |=> cfg_ack_o && cfg_rdata_o == CLASS_WORD;
  endproperty
  a_class_word: assert property (p_class_word)
    else $error("class word read back wrong");

  property p_header_zero;
    @(posedge clk_i) disable iff (rst_i)
      s_read(OFS_TENURE) |=> cfg_rdata_o[31:16] == 16'h0000 &&
        cfg_rdata_o[15:0] == {$past(tenure_limit), $past(line_length)};
  endproperty
  a_header_zero: assert property (p_header_zero)
    else $error("header or self-test byte nonzero");

  property p_base_fill;
    @(posedge clk_i) disable iff (rst_i)
      s_base_fill ##2 s_read(OFS_BASE) |=> cfg_rdata_o == 32'hFFFFF800;
  endproperty
  a_base_fill: assert property (p_base_fill)
    else $error("base all-ones readback wrong");

  property p_base_low;
    @(posedge clk_i) disable iff (rst_i)
      s_read(OFS_BASE) |=> cfg_rdata_o[10:0] == 11'h000;
  endproperty
  a_base_low: assert property (p_base_low)
    else $error("base low bits nonzero");

  property p_reset_values;
    @(posedge clk_i)
      rst_i |=> tenure_limit == 8'h00 && line_length == 8'h00 &&
               window_base == '0;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("writable fields not zero after reset");

  property p_ro_write;
    @(posedge clk_i) disable iff (rst_i)
      (wr_hit && cfg_addr_i == OFS_CLASS) |=>
        $stable(tenure_limit) && $stable(line_length) && $stable(window_base);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write changed state");

  property p_lane_mask;
    @(posedge clk_i) disable iff (rst_i)
      (wr_hit && cfg_addr_i == OFS_TENURE && cfg_be_i == 4'h1) |=>
        $stable(tenure_limit) && line_length == $past(cfg_wdata_i[7:0]);
  endproperty
  a_lane_mask: assert property (p_lane_mask)
    else $error("byte lane mask not honoured");

  property p_claim;
    @(posedge clk_i) disable iff (rst_i)
      (mem_req_i && memory_response_enable_i &&
       mem_addr_i[31:11] == window_base) |-> mem_hit_o;
  endproperty
  a_claim: assert property (p_claim)
    else $error("matching memory cycle not claimed");
endmodule

// ==== sim/hcp_host_model.sv ====
// Host bridge model issuing configuration and memory cycles
`timescale 1ns/10ps
module hcp_host_model (
  input  wire logic        clk_i,
  input  wire logic        cfg_ack_i,
  input  wire logic [31:0] cfg_rdata_i,
  input  wire logic        mem_hit_i,
  output logic             cfg_req_o,
  output logic             cfg_we_o,
  output logic [7:0]       cfg_addr_o,
  output logic [3:0]       cfg_be_o,
  output logic [31:0]      cfg_wdata_o,
  output logic             mem_enable_o,
  output logic             mem_req_o,
  output logic [31:0]      mem_addr_o
);
  initial begin
    cfg_req_o = 1'b0;
    cfg_we_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0;
    mem_enable_o = 1'b0;
    mem_req_o = 1'b0;
    mem_addr_o = 32'h0;
  end
  // One-cycle request, answer read in the ack cycle
  task automatic cfg_access(input logic we, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d,
      output logic [31:0] rd, output logic ack);
    @(posedge clk_i);
    cfg_req_o <= 1'b1;
    cfg_we_o <= we;
    cfg_addr_o <= a;
    cfg_be_o <= be;
    cfg_wdata_o <= d;
    @(posedge clk_i);
    cfg_req_o <= 1'b0;
    // Released lines do not keep the last value
    cfg_addr_o <= ~a;
    cfg_be_o <= ~be;
    cfg_wdata_o <= ~d;
    #1;
    rd = cfg_rdata_i;
    ack = cfg_ack_i;
  endtask
  task automatic mem_probe(input logic en, input logic [31:0] a,
      output logic hit);
    @(posedge clk_i);
    mem_enable_o <= en;
    mem_req_o <= 1'b1;
    mem_addr_o <= a;
    #1;
    hit = mem_hit_i;
    @(posedge clk_i);
    mem_req_o <= 1'b0;
    mem_addr_o <= ~a;
  endtask
endmodule

// ==== sim/hcp_config_header_bench.sv ====
// Self-checking bench for the configuration header slice
`timescale 1ns/10ps
module hcp_config_header_bench;
  import hcp_pkg::*;
  localparam logic [7:0] REV = 8'h5A; // Arbitrary value
  logic        clk_i, rst_i, req, we, ack_w, en, mreq, hit_w;
  logic        frame, active, gnt_n, expired, stop, ack, hit;
  logic [7:0]  addr, line_len, line_use, limit, line;
  logic [3:0]  be, cmd, be_r;
  logic [31:0] wd, rd_w, maddr, ptr, rd, d_r, a_r;
  logic [20:0] base;
  int          fail_count, check_count, cycles;
  hcp_config_header #(.SILICON_REVISION(REV)) hcp_config_header_i (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_req_i(req), .cfg_we_i(we),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd),
    .cfg_rdata_o(rd_w), .cfg_ack_o(ack_w),
    .memory_response_enable_i(en), .mem_req_i(mreq),
    .mem_addr_i(maddr), .mem_hit_o(hit_w), .frame_start_i(frame),
    .xfer_active_i(active), .gnt_n_i(gnt_n), .init_cmd_i(cmd),
    .tenure_expired_o(expired), .tenure_stop_o(stop),
    .line_length_setting_o(line_len), .line_length_use_o(line_use),
    .window_base_pointer_o(ptr));
  hcp_host_model hcp_host_model_i (
    .clk_i(clk_i), .cfg_ack_i(ack_w), .cfg_rdata_i(rd_w),
    .mem_hit_i(hit_w), .cfg_req_o(req), .cfg_we_o(we),
    .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wd),
    .mem_enable_o(en), .mem_req_o(mreq), .mem_addr_o(maddr));
  task automatic end_of_test;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] s, e, input string m);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s %h %h", $time, m, s, e);
    end
  endtask
  task automatic cfg(input logic w, input logic [7:0] a,
      input logic [3:0] b, input logic [31:0] d);
    hcp_host_model_i.cfg_access(w, a, b, d, rd, ack);
    check({31'h0, ack}, 32'h1, "no ack");
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input string m);
    cfg(1'b0, a, 4'hF, 32'h0);
    check(rd, e, m);
  endtask
  function automatic logic [20:0] next_base(input logic [20:0] b,
      input logic [3:0] m, input logic [31:0] d);
    next_base = b;
    if (m[3]) next_base[20:13] = d[31:24];
    if (m[2]) next_base[12:5] = d[23:16];
    if (m[1]) next_base[4:0] = d[15:11];
  endfunction
  task automatic tenure_run(input logic [7:0] lim);
    int n;
    @(posedge clk_i);
    frame <= 1'b1;
    active <= 1'b1;
    gnt_n <= 1'b0;
    @(posedge clk_i);
    frame <= 1'b0;
    n = 1;
    #1;
    while (expired !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(n, {24'h0, lim} + 32'h1, "expiry");
    check({31'h0, stop}, 32'h0, "stop early");
    @(posedge clk_i);
    gnt_n <= 1'b1;
    #1;
    check({31'h0, stop}, 32'h1, "no stop");
    @(posedge clk_i);
    active <= 1'b0;
    gnt_n <= 1'b0;
    #1;
    check({31'h0, stop}, 32'h0, "stop stuck");
    @(posedge clk_i);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    {frame, active, gnt_n, cmd} = 7'h0;
    {fail_count, check_count, cycles} = 0;
    {base, limit, line} = 37'h0;
    void'($urandom(72));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_CLASS, {8'h0C, 8'h00, 8'h10, REV},
      "class");
    rd_chk(OFS_TENURE, 32'h0, "tenure rst");
    rd_chk(OFS_BASE, 32'h0, "base rst");
    rd_chk(8'h14, 32'h0, "unmapped");
    cfg(1'b1, OFS_CLASS, 4'hF, 32'hFFFF_FFFF);
    rd_chk(OFS_CLASS, {8'h0C, 8'h00, 8'h10, REV}, "class wr");
    cfg(1'b1, OFS_BASE, 4'hF, 32'hFFFF_FFFF);
    base = 21'h1FFFFF;
    check(ptr, 32'hFFFF_F800, "ptr");
    rd_chk(OFS_BASE, 32'hFFFF_F800,
      "sizing");
    cfg(1'b1, OFS_TENURE, 4'hF, 32'hFFFF_FFFF);
    {limit, line} = 16'hFFFF;
    rd_chk(OFS_TENURE, 32'h0000_FFFF, "ro bytes");
    for (int i = 0; i < 24; i++) begin
      be_r = 4'($urandom);
      d_r = $urandom;
      cfg(1'b1, OFS_BASE, be_r, d_r);
      base = next_base(base, be_r, d_r);
      rd_chk(OFS_BASE, {base, 11'h0}, "base");
      cfg(1'b1, OFS_TENURE, be_r, d_r);
      if (be_r[1]) limit = d_r[15:8];
      if (be_r[0]) line = d_r[7:0];
      rd_chk(OFS_TENURE, {16'h0, limit, line},
        "tenure");
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      cmd <= (i == 3) ? 4'h7 : 4'hC + 4'(i + (i > 0 ? 1 : 0));
      #1;
      check({24'h0, line_use}, {24'h0, (i == 3) ? 8'h00 : line},
        "use");
      check({24'h0, line_len}, {24'h0, line}, "line");
    end
    for (int i = 0; i < 40; i++) begin
      a_r = $urandom;
      if (i % 2 == 1) a_r[31:11] = base;
      hcp_host_model_i.mem_probe(1'($urandom), a_r, hit);
      check({31'h0, hit}, {31'h0, en && a_r[31:11] == base},
        "claim");
    end
    for (int t = 0; t < 4; t++) begin
      limit = (t == 0) ? 8'h00 : 8'($urandom_range(1, 6));
      cfg(1'b1, OFS_TENURE, 4'h2, {16'h0, limit, 8'h00});
      tenure_run(limit);
    end
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(OFS_BASE, 32'h0, "base rerst");
    end_of_test();
  end
endmodule
